// ==== core/dsse_pkg.sv ====
package dsse_pkg;
    // drive state codes as presented by the state machine input
    localparam logic [3:0] DSSE_ST_NOT_READY  = 4'h2;
    localparam logic [3:0] DSSE_ST_SW_ON_DIS  = 4'h3;
    localparam logic [3:0] DSSE_ST_READY      = 4'h4;
    localparam logic [3:0] DSSE_ST_SWITCHED   = 4'h5;
    localparam logic [3:0] DSSE_ST_OP_ENABLE  = 4'h6;
    localparam logic [3:0] DSSE_ST_QSTOP      = 4'h7;
    localparam logic [3:0] DSSE_ST_FAULT      = 4'h9;

    // register address of the status word on the parameter port
    localparam logic [15:0] DSSE_ADDR_STATUS  = 16'h6041;
    localparam logic [15:0] DSSE_STATUS_RESET = 16'h0000;

    // status word bit positions
    localparam int DSSE_B_RDY_SW_ON  = 0;
    localparam int DSSE_B_SW_ON      = 1;
    localparam int DSSE_B_OP_EN      = 2;
    localparam int DSSE_B_FAULT      = 3;
    localparam int DSSE_B_VOLT       = 4;
    localparam int DSSE_B_QSTOP      = 5;
    localparam int DSSE_B_SW_ON_DIS  = 6;
    localparam int DSSE_B_WARN       = 7;
    localparam int DSSE_B_HALT       = 8;
    localparam int DSSE_B_REMOTE     = 9;
    localparam int DSSE_B_TARGET     = 10;
    localparam int DSSE_B_RSVD       = 11;
    localparam int DSSE_B_MODE_SPEC  = 12;
    localparam int DSSE_B_PROC_ERR   = 13;
    localparam int DSSE_B_PROC_END   = 14;
    localparam int DSSE_B_REF_OK     = 15;

    // clock and warning hold timing
    localparam int DSSE_CLK_HZ         = 50_000_000;
    localparam int DSSE_WARN_HOLD_MS   = 100;
    localparam int DSSE_WARN_HOLD_CYC  = (DSSE_CLK_HZ / 1000) * DSSE_WARN_HOLD_MS;

    // process-done tracking states
    typedef enum logic [2:0] {
        DSSE_PE_IDLE = 3'b001,
        DSSE_PE_RUN  = 3'b010,
        DSSE_PE_STOP = 3'b100
    } dsse_pe_e;
endpackage

// ==== core/dsse_warn_hold.sv ====
`timescale 1ns/1ps
`default_nettype none
// stretches the warning flag to a minimum hold time, cleared by fault reset
module dsse_warn_hold #(
    parameter int HOLD_CYC = 5_000_000
) (
    input  wire logic core_clk,
    input  wire logic arst_n,
    input  wire logic warn_pending,
    input  wire logic fault_reset,
    output logic      warn_flag
);
    import dsse_pkg::*;

    localparam int CW = $clog2(HOLD_CYC + 1);

    initial begin
        if (HOLD_CYC < 1) begin
            $error("hold count must be at least one cycle");
        end
    end

    logic [CW-1:0] cnt_q;   // cycles left in minimum hold
    logic          flag_q;  // warning bit

    // hold counter reloads while a warning is pending
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= '0;
        end else if (warn_pending) begin
            cnt_q <= CW'(HOLD_CYC - 1);
        end else if (fault_reset) begin
            cnt_q <= '0;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - CW'(1);
        end
    end

    // flag follows pending list, stretched by counter
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            flag_q <= 1'b0;
        end else begin
            // a warning still pending wins over a fault reset in the same cycle
            flag_q <= warn_pending || (!fault_reset && (cnt_q != '0));
        end
    end

    assign warn_flag = flag_q;
endmodule
`default_nettype wire

// ==== core/dsse_status_encoder.sv ====
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - local outputs follow state table for states
// - state shown in bits 0-3,5,6
// - states 2,3 clear low bits; 3 sets bit6
// - states 4-6 ready bits, quick stop set
// - state 7 and 9 encodings as tabled
// - bit 4 shows DC bus ok; gates 3-to-4
// - bit 7 set while any warning pending
// - warning bit held at least 100 ms
// - fault reset clears warning bit at once
// - warning never stops running movement mode
// - bit 8 follows active halt
// - bit 9 set under fieldbus command control
// - bit 10 low while running, halted, errored; here process_error is not used, and a halt clears it only while a mode stops
// - bit 12 from active mode's monitor condition
// - bit 13 set on error needing rectification
// - bit 14 cleared when a mode starts
// - bit 14 set again at standstill after end
// - no bit 14 return when new mode follows
// - bit 15 while reference point valid
module dsse_status_encoder #(
    parameter int WARN_HOLD_CYC = dsse_pkg::DSSE_WARN_HOLD_CYC
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    // drive state and level conditions
    input  wire logic [3:0]  drive_state,
    input  wire logic        local_mode,
    input  wire logic        dc_bus_ok,
    input  wire logic        warn_pending,
    input  wire logic        fault_reset,
    input  wire logic        halt_active,
    input  wire logic        fieldbus_remote,
    // process events from the motion core
    input  wire logic        mode_start,
    input  wire logic        mode_success,
    input  wire logic        mode_abort,
    input  wire logic        mode_change,
    input  wire logic        motor_standstill,
    input  wire logic        mode_monitor,
    input  wire logic        process_error,
    input  wire logic        ref_valid,
    input  wire logic        move_run_req,
    // parameter port requests
    input  wire logic        par_rd,
    input  wire logic        par_wr,
    input  wire logic [15:0] par_addr,
    input  wire logic [15:0] par_wdata,
    // read answer, status word and discrete outputs
    output logic [15:0]      par_rdata,
    output logic             par_err,
    output logic [15:0]      drive_status_word,
    output logic             fault_free_output,
    output logic             power_stage_active_output,
    output logic             ready_to_switch_on_ok,
    output logic             movement_enable
);
    import dsse_pkg::*;

    // latency overview
    //   status word: one register stage behind its level inputs
    //   warning bit: two stages, the hold stretcher and the status register
    //   target reached and process done: two stages, tracker and status register
    //   read data: copied from the registered word at the taking edge
    //   local outputs, transition gate, movement enable: one stage each
    //
    // limits a user must know
    //   mode_success has to stand until the motor rests, or target reached stays low
    //   the real warning hold count is large; short counts suit simulation only
    //   the status word is rebuilt every cycle; nothing in it is sticky
    //   except the warning stretch and the two tracker flags
    //
    // reset
    //   every register clears asynchronously; the word reads zero during
    //   reset and for the first edge after release, until inputs reach it
    //   the tracker starts idle with both process flags low
    //
    // flag priority
    //   a pending warning wins over a fault reset in the same cycle
    //   a start wins over standstill while stopping
    //   abort or halt together with success: no target reached

    // refuse hold counts the stretcher cannot serve
    // a zero count would make the warning bit vanish at once
    initial begin
        if (WARN_HOLD_CYC < 1) begin
            $error("warning hold must be at least one cycle");
        end
    end

    logic [15:0] status_d;       // next status word
    logic [15:0] status_q;       // registered status word
    logic [15:0] rdata_q;        // read data register
    logic        err_q;          // access error flag
    logic        nofault_q;      // fault-free discrete output
    logic        pwr_q;          // power stage discrete output
    logic        rdy_ok_q;       // permission for 3-to-4 transition
    logic        mv_en_q;        // movement enable towards motion core
    logic        warn_flag;      // stretched warning
    logic        target_q;       // target reached flag
    logic        pend_q;         // process done flag
    logic        follow_q;       // mode change seen while running
    dsse_pe_e    pe_q;           // process tracking state
    logic [6:0]  sbits;          // state bits 6..0 (bit 4 unused here)

    // minimum hold for the warning bit
    //   the stretcher reloads while any warning is pending and counts
    //   down afterwards; a fault reset clears it unless a warning is
    //   still pending in the same cycle
    //   its hold count is a parameter, the real default being 100 ms
    dsse_warn_hold #(
        .HOLD_CYC     (WARN_HOLD_CYC)
    ) u_warn (
        .core_clk     (core_clk),
        .arst_n       (arst_n),
        .warn_pending (warn_pending),
        .fault_reset  (fault_reset),
        .warn_flag    (warn_flag)
    );

    // state table into status bits; unused bit 4 reads zero
    //   code  b6 b5 b3 b2 b1 b0
    //   2     0  0  0  0  0  0
    //   3     1  0  0  0  0  0
    //   4     0  1  0  0  0  1
    //   5     0  1  0  0  1  1
    //   6     0  1  0  1  1  1
    //   7     0  0  0  1  1  1
    //   9     0  0  1  1  1  1
    //   other codes give zeros, so a bad code never shows a stale state
    //   bit 4 of this vector stays zero; the bus voltage bit is added later
    //   the case is unique: each code selects one row
    always_comb begin
        sbits = 7'h00;
        unique case (drive_state)
            DSSE_ST_NOT_READY: begin
                sbits = 7'h00;
            end
            DSSE_ST_SW_ON_DIS: begin
                sbits = 7'h40;
            end
            DSSE_ST_READY: begin
                sbits = 7'h21;
            end
            DSSE_ST_SWITCHED: begin
                sbits = 7'h23;
            end
            DSSE_ST_OP_ENABLE: begin
                sbits = 7'h27;
            end
            DSSE_ST_QSTOP: begin
                sbits = 7'h07;
            end
            DSSE_ST_FAULT: begin
                sbits = 7'h0f;
            end
            default: begin
                sbits = 7'h00;
            end
        endcase
    end

    // process tracking for target reached and process done
    //   idle: no mode running; waits for a start
    //   run:  a mode is moving; success, abort or halt ends it
    //   stop: mode has ended; waits for the motor to rest
    //   a start while stopping goes straight back to run, so the done
    //   flag does not blink between two back-to-back modes
    //   a mode change seen while running marks the next mode as a
    //   follow-on of another type, which keeps the done flag low
    //   target reached is decided at standstill: success with no abort
    //   and no halt; a halt or an abort leaves it low
    //   abort and halt are treated alike for the done flag
    //   both flags drop at every start
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pe_q     <= DSSE_PE_IDLE;
            target_q <= 1'b0;
            pend_q   <= 1'b0;
            follow_q <= 1'b0;
        end else begin
            unique case (pe_q)
                DSSE_PE_IDLE: begin
                    if (mode_start) begin
                        pe_q     <= DSSE_PE_RUN;
                        pend_q   <= 1'b0;
                        target_q <= 1'b0;
                        follow_q <= 1'b0;
                    end
                end
                DSSE_PE_RUN: begin
                    target_q <= 1'b0;
                    if (mode_change) begin
                        follow_q <= 1'b1;
                    end
                    if (mode_success || mode_abort || halt_active) begin
                        pe_q <= DSSE_PE_STOP;
                        // target stays low here; decided later at standstill
                        target_q <= 1'b0;
                        follow_q <= follow_q || mode_change;
                    end
                end
                DSSE_PE_STOP: begin
                    if (mode_start) begin
                        pe_q     <= DSSE_PE_RUN;
                        pend_q   <= 1'b0;
                        target_q <= 1'b0;
                        follow_q <= 1'b0;
                    end else if (motor_standstill) begin
                        pe_q   <= DSSE_PE_IDLE;
                        pend_q <= !follow_q;
                        target_q <= mode_success && !mode_abort && !halt_active;
                    end
                end
            endcase
        end
    end

    // assemble the status word
    //   bits 0-3, 5, 6  state table
    //   bit 4           bus voltage correct
    //   bit 7           stretched warning
    //   bit 8           halt active
    //   bit 9           fieldbus command control
    //   bit 10          target reached, only while idle and at rest
    //   bit 11          reserved, always zero
    //   bit 12          monitor condition of the active mode
    //   bit 13          process error
    //   bit 14          process done
    //   bit 15          reference point valid
    always_comb begin
        status_d                   = DSSE_STATUS_RESET;
        status_d[DSSE_B_RDY_SW_ON] = sbits[DSSE_B_RDY_SW_ON];
        status_d[DSSE_B_SW_ON]     = sbits[DSSE_B_SW_ON];
        status_d[DSSE_B_OP_EN]     = sbits[DSSE_B_OP_EN];
        status_d[DSSE_B_FAULT]     = sbits[DSSE_B_FAULT];
        status_d[DSSE_B_QSTOP]     = sbits[DSSE_B_QSTOP];
        status_d[DSSE_B_SW_ON_DIS] = sbits[DSSE_B_SW_ON_DIS];
        status_d[DSSE_B_VOLT]      = dc_bus_ok;
        status_d[DSSE_B_WARN]      = warn_flag;
        status_d[DSSE_B_HALT]      = halt_active;
        status_d[DSSE_B_REMOTE]    = fieldbus_remote;
        status_d[DSSE_B_TARGET]    = target_q && motor_standstill && pe_q == DSSE_PE_IDLE;
        status_d[DSSE_B_RSVD]      = 1'b0;
        status_d[DSSE_B_MODE_SPEC] = mode_monitor;
        status_d[DSSE_B_PROC_ERR]  = process_error;
        status_d[DSSE_B_PROC_END]  = pend_q;
        status_d[DSSE_B_REF_OK]    = ref_valid;
    end

    // status word register, updated every clock
    //   a single stage keeps all bits of one read coherent: they come
    //   from the same edge, never half old and half new
    //   reset value is all zero
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            status_q <= DSSE_STATUS_RESET;
        end else begin
            status_q <= status_d;
        end
    end

    // parameter port: reads return status, writes refused
    //   one address only; any other read returns zero with an error pulse
    //   a write never reaches the word and always pulses the error flag
    //   a read and a write in one cycle: the read is served, error pulses
    //   read data stands until the next read; the error flag for one cycle
    //   the taking edge copies the word as it stood before that edge
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= DSSE_STATUS_RESET;
            err_q   <= 1'b0;
        end else begin
            err_q <= 1'b0;
            if (par_rd && par_addr == DSSE_ADDR_STATUS) begin
                rdata_q <= status_q;
            end else if (par_rd) begin
                rdata_q <= DSSE_STATUS_RESET;  // unmapped address
                err_q   <= 1'b1;
            end
            if (par_wr) begin
                err_q <= 1'b1;
            end
        end
    end

    // discrete outputs in local control mode
    //   code  fault-free  power stage
    //   4     1           0
    //   5     1           0
    //   6     1           1
    //   7     0           1
    //   other 0           0
    //   both outputs stay low outside local control mode
    //   outputs lag the state by one clock
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            nofault_q <= 1'b0;
            pwr_q     <= 1'b0;
        end else begin
            nofault_q <= local_mode && (drive_state == DSSE_ST_READY ||
                         drive_state == DSSE_ST_SWITCHED ||
                         drive_state == DSSE_ST_OP_ENABLE);
            pwr_q     <= local_mode && (drive_state == DSSE_ST_OP_ENABLE ||
                         drive_state == DSSE_ST_QSTOP);
        end
    end

    // transition gate and movement enable
    //   the gate tells the state logic whether leaving switch-on disabled
    //   for ready to switch on is allowed: only with the bus voltage correct
    //   movement enable only mirrors the request; a pending warning is
    //   not part of it, so warnings never stop a movement
    //   both are registered so they change only on a clock edge
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdy_ok_q <= 1'b0;
            mv_en_q  <= 1'b0;
        end else begin
            rdy_ok_q <= dc_bus_ok;
            mv_en_q  <= move_run_req;
        end
    end

    assign drive_status_word         = status_q;
    assign par_rdata                 = rdata_q;
    assign par_err                   = err_q;
    assign fault_free_output         = nofault_q;
    assign power_stage_active_output = pwr_q;
    assign ready_to_switch_on_ok     = rdy_ok_q;
    assign movement_enable           = mv_en_q;

    // par_wdata ignored: word is read-only
    // the reduction only keeps the port read; its value goes nowhere
    // writes are still seen through par_wr for the error pulse
    logic unused_wdata;
    assign unused_wdata = ^par_wdata;
endmodule
`default_nettype wire

// ==== testbench/dsse_status_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
// watches status word, local outputs and register port of the encoder
module dsse_status_checker #(
    parameter int WARN_HOLD_CYC = 20
) (
    input wire logic        core_clk,
    input wire logic        arst_n,
    input wire logic [3:0]  drive_state,
    input wire logic        local_mode,
    input wire logic        dc_bus_ok,
    input wire logic        warn_pending,
    input wire logic        fault_reset,
    input wire logic        halt_active,
    input wire logic        fieldbus_remote,
    input wire logic        mode_start,
    input wire logic        mode_monitor,
    input wire logic        process_error,
    input wire logic        ref_valid,
    input wire logic        move_run_req,
    input wire logic        par_rd,
    input wire logic        par_wr,
    input wire logic [15:0] par_addr,
    input wire logic [15:0] par_rdata,
    input wire logic        par_err,
    input wire logic [15:0] drive_status_word,
    input wire logic        fault_free_output,
    input wire logic        power_stage_active_output,
    input wire logic        ready_to_switch_on_ok,
    input wire logic        movement_enable
);
    import dsse_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    wire logic [15:0] sw = drive_status_word; // short alias
    logic      [31:0] hold_q;                 // cycles the warning bit has stood
    // expected state bits 6,5,3..0 for a state code
    function automatic logic [15:0] low_bits(logic [3:0] st);
        case (st)
            4'h3: return 16'h0040;
            4'h4: return 16'h0021;
            4'h5: return 16'h0023;
            4'h6: return 16'h0027;
            4'h7: return 16'h0007;
            4'h9: return 16'h000f;
            default: return 16'h0000;
        endcase
    endfunction
    // counts how long the warning bit has been high
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) hold_q <= 32'h0;
        else hold_q <= sw[7] ? hold_q + 32'h1 : 32'h0;
    end
    AST_FAULT_FREE: assert property (local_mode |=> fault_free_output == ($past(drive_state) inside {4'h4, 4'h5, 4'h6}))
        else $error("fault free output wrong");
    AST_POWER: assert property (local_mode |=> power_stage_active_output == ($past(drive_state) inside {4'h6, 4'h7}))
        else $error("power stage output wrong");
    AST_STATE_BITS: assert property (1'b1 |=> (sw & 16'h006f) == low_bits($past(drive_state)))
        else $error("state bits wrong");
    AST_PASS_BITS: assert property (1'b1 |=> {sw[15], sw[13:12], sw[9:8], sw[4]} ==
        $past({ref_valid, process_error, mode_monitor, fieldbus_remote, halt_active, dc_bus_ok}))
        else $error("flag bits wrong");
    AST_WARN_SET: assert property (warn_pending |-> ##2 sw[7])
        else $error("warning bit not set");
    AST_WARN_CLR: assert property (fault_reset && !warn_pending |-> ##2 !sw[7])
        else $error("warning bit not cleared");
    AST_WARN_HOLD: assert property ($fell(sw[7]) && !$past(fault_reset, 2) |-> hold_q >= 32'(WARN_HOLD_CYC))
        else $error("warning bit held too briefly");
    AST_RSVD: assert property (sw[11] == 1'b0)
        else $error("reserved bit set");
    AST_MOVE: assert property (1'b1 |=> movement_enable == $past(move_run_req))
        else $error("movement enable wrong");
    AST_GATE: assert property (1'b1 |=> ready_to_switch_on_ok == $past(dc_bus_ok))
        else $error("transition gate wrong");
    AST_END_CLR: assert property (mode_start |-> ##[1:2] !sw[14])
        else $error("process done bit not cleared");
    AST_RD: assert property (par_rd && par_addr == DSSE_ADDR_STATUS |=> par_rdata == $past(sw) && !par_err)
        else $error("status read wrong");
    AST_WR: assert property (par_wr |=> par_err)
        else $error("write not refused");
endmodule
bind dsse_status_encoder dsse_status_checker #(.WARN_HOLD_CYC(WARN_HOLD_CYC)) u_dsse_status_checker (
    .core_clk, .arst_n, .drive_state, .local_mode, .dc_bus_ok, .warn_pending, .fault_reset, .halt_active,
    .fieldbus_remote, .mode_start, .mode_monitor, .process_error, .ref_valid, .move_run_req, .par_rd, .par_wr,
    .par_addr, .par_rdata, .par_err, .drive_status_word, .fault_free_output, .power_stage_active_output,
    .movement_enable, .ready_to_switch_on_ok
);
`default_nettype wire

// ==== testbench/dsse_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// host that reads the status word and owns the control word
module dsse_host_model (
    input  wire logic   core_clk,
    output logic        par_rd,
    output logic        par_wr,
    output logic [15:0] par_addr,
    output logic [15:0] par_wdata,
    output logic        halt_active
);
    logic [15:0] ctl_q = 16'h0000; // drive control word
    initial {par_rd, par_wr, par_addr, par_wdata} = 34'h0;
    assign halt_active = ctl_q[8];
    // one-cycle strobe; address and data invert once released
    task automatic access(input logic wr, input logic [15:0] a);
        @(posedge core_clk);
        par_rd <= !wr;
        par_wr <= wr;
        par_addr <= a;
        par_wdata <= 16'($urandom);
        @(posedge core_clk);
        par_rd <= 1'b0;
        par_wr <= 1'b0;
        par_addr <= ~a;
        par_wdata <= ~par_wdata;
    endtask
endmodule
`default_nettype wire

// ==== testbench/dsse_status_encoder_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module dsse_status_encoder_test;
    import dsse_pkg::*;
    localparam int HOLD = 20; // shortened warning hold
    logic core_clk = 1'b0, arst_n = 1'b0, rd_q = 1'b0;
    logic [3:0] drive_state = 4'h2;
    logic local_mode = 0, dc_bus_ok = 0, warn_pending = 0, fault_reset = 0, fieldbus_remote = 0, mode_start = 0;
    logic mode_success = 0, mode_abort = 0, mode_change = 0, motor_standstill = 1, mode_monitor = 0;
    logic process_error = 0, ref_valid = 0, move_run_req = 0, par_rd, par_wr, par_err, halt_active;
    logic ffo, pso, rts, mve;
    logic [15:0] par_addr, par_wdata, par_rdata, drive_status_word;
    logic [16:0] exp_q[$], msk_q[$]; // expected read answers and masks
    logic [3:0] sts[8] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hc};
    int fail_count = 0, tests_run = 0;
    always #10 core_clk = ~core_clk;
    dsse_status_encoder #(.WARN_HOLD_CYC(HOLD)) u_dsse_status_encoder (.core_clk, .arst_n, .drive_state,
        .local_mode, .dc_bus_ok, .warn_pending, .fault_reset, .halt_active, .fieldbus_remote, .mode_start,
        .mode_success, .mode_abort, .mode_change, .motor_standstill, .mode_monitor, .process_error, .ref_valid,
        .move_run_req, .par_rd, .par_wr, .par_addr, .par_wdata, .par_rdata, .par_err, .drive_status_word,
        .fault_free_output(ffo), .power_stage_active_output(pso), .ready_to_switch_on_ok(rts), .movement_enable(mve));
    dsse_host_model u_dsse_host_model (.core_clk, .par_rd, .par_wr, .par_addr, .par_wdata, .halt_active);
    task automatic chk(string name, logic [16:0] seen, logic [16:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // expected word from the inputs now applied; t, e, w give bits 10, 14, 7
    function automatic logic [15:0] word(logic t, logic e, logic w);
        logic [15:0] lo;
        case (drive_state)
            4'h3: lo = 16'h0040;
            4'h4: lo = 16'h0021;
            4'h5: lo = 16'h0023;
            4'h6: lo = 16'h0027;
            4'h7: lo = 16'h0007;
            4'h9: lo = 16'h000f;
            default: lo = 16'h0000;
        endcase
        return lo | {ref_valid, e, process_error, mode_monitor, 1'b0, t, fieldbus_remote, halt_active, w, 2'b00,
            dc_bus_ok, 4'h0};
    endfunction
    // let inputs settle, note the answer, then read the status word
    task automatic look(logic t, logic e, logic w, logic [15:0] m);
        repeat (4) @(posedge core_clk);
        exp_q.push_back({1'b0, word(t, e, w) & m});
        msk_q.push_back({1'b1, m});
        u_dsse_host_model.access(1'b0, DSSE_ADDR_STATUS);
    endtask
    task automatic pulse_start();
        @(posedge core_clk);
        mode_start <= 1'b1;
        motor_standstill <= 1'b0;
        mode_success <= 1'b0;
        @(posedge core_clk);
        mode_start <= 1'b0;
    endtask
    // compares each read answer with the oldest note
    always @(posedge core_clk) rd_q <= par_rd;
    always @(negedge core_clk) begin
        if (rd_q) chk("read", {par_err, par_rdata} & msk_q.pop_front(), exp_q.pop_front());
    end
    initial begin
        repeat (5000) @(posedge core_clk);
        fail_count++;
        end_sim();
    end
    initial begin
        void'($urandom(32'hfcc2));
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
        foreach (sts[i]) begin
            @(posedge core_clk);
            drive_state <= sts[i];
            {local_mode, dc_bus_ok, fieldbus_remote, mode_monitor, process_error, ref_valid, move_run_req} <= 7'($urandom);
            u_dsse_host_model.ctl_q <= 16'($urandom) & 16'h0100;
            look(1'b0, 1'b0, 1'b0, 16'hbbff);
        end
        u_dsse_host_model.ctl_q <= 16'h0000;
        drive_state <= 4'h6;
        pulse_start();
        look(1'b0, 1'b0, 1'b0, 16'hffff);
        mode_success <= 1'b1;
        motor_standstill <= 1'b1;
        look(1'b1, 1'b1, 1'b0, 16'hffff);
        pulse_start();
        u_dsse_host_model.ctl_q <= 16'h0100;
        motor_standstill <= 1'b1;
        look(1'b0, 1'b1, 1'b0, 16'hffff);
        u_dsse_host_model.ctl_q <= 16'h0000;
        pulse_start();
        mode_change <= 1'b1;
        @(posedge core_clk);
        mode_change <= 1'b0;
        mode_success <= 1'b1;
        motor_standstill <= 1'b1;
        look(1'b0, 1'b0, 1'b0, 16'hfbff);
        pulse_start();
        mode_success <= 1'b1;
        mode_abort <= 1'b1;
        motor_standstill <= 1'b1;
        look(1'b0, 1'b1, 1'b0, 16'hffff);
        mode_abort <= 1'b0;
        warn_pending <= 1'b1;
        move_run_req <= 1'b1;
        @(posedge core_clk);
        warn_pending <= 1'b0;
        look(1'b0, 1'b0, 1'b1, 16'hbbff);
        repeat (HOLD) @(posedge core_clk);
        look(1'b0, 1'b0, 1'b0, 16'hbbff);
        warn_pending <= 1'b1;
        look(1'b0, 1'b0, 1'b1, 16'hbbff);
        warn_pending <= 1'b0;
        fault_reset <= 1'b1;
        @(posedge core_clk);
        fault_reset <= 1'b0;
        look(1'b0, 1'b0, 1'b0, 16'hbbff);
        u_dsse_host_model.access(1'b1, DSSE_ADDR_STATUS);
        exp_q.push_back(17'h10000);
        msk_q.push_back(17'h1ffff);
        u_dsse_host_model.access(1'b0, 16'h6040);
        look(1'b0, 1'b0, 1'b0, 16'hbbff);
        repeat (3) @(posedge core_clk);
        chk("notes left", 17'(exp_q.size()), 17'h0);
        end_sim();
    end
endmodule
`default_nettype wire
